// ---- core/bcr_bay_control.sv ----
// bay control and enable register with avalon-mm slave and request strobe
//
// Design decisions made here: register access over Avalon-MM and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "bcr_consts.svh"

// Overview of operation
// - each bay has its own 32-bit control register that is all zeros after reset.
// - bits 31 to 8 always read as zero and writes to them are ignored.
// - a one in bit 7 drives the interlock output to hold the unit in the bay.
// - a zero in bit 7 releases the interlock so the unit can be removed.
// - bits 6 to 4 carry a request code: 1 inserted, 2 enabled, 3 removal requested, 4 removal allowed, 0 none.
// - codes 5, 6 and 7 are reserved and never change the bay state.
// - reading the request field returns the last code written, not the bay state.
// - writing 0 to the request field keeps the old value and requests nothing.
// - every legal nonzero code written with a device present is passed to the bay state machine as a request.
// - a request acts only in the cycle after its write and only with a device present.
// - requests are never stored or queued; one that cannot act is lost.
// - with no device present a nonzero write makes no transition but is still stored.
// - the field can be cleared to zero by the bay state machine on a clear input.
// - the bay state machine may override the stored request field on hardware events or bad codes.
// - power enable cannot be set while the interlock is released and is cleared when it is.
module bcr_bay_control
    import bcr_pkg::*;
(
    input  wire logic        sys_clk,            // system clock, 200 mhz
    input  wire logic        reset,              // asynchronous reset, active high
    input  wire logic [3:0]  avs_address,        // byte address
    input  wire logic        avs_read,           // read request
    input  wire logic        avs_write,          // write request
    input  wire logic [31:0] avs_writedata,      // write data
    input  wire logic [3:0]  avs_byteenable,     // byte enables
    output logic [31:0]      avs_readdata,       // read data
    output logic             avs_waitrequest,    // stall while answer not ready
    input  wire logic        device_present,     // a device sits in the bay
    input  wire logic        request_clear,      // state machine clears the request field
    input  wire logic        override_valid,     // state machine overrides the request field
    input  wire logic [2:0]  override_code,      // code written by the override
    output logic             interlock_engage,   // interlock held closed
    output logic [2:0]       bay_state_request,  // stored request field
    output logic             bay_power_enable,   // bay power rail enable
    output logic [3:0]       bay_enable_bits,    // bits 3 to 0 as stored
    output logic             state_req_valid,    // one-cycle request pulse
    output logic [2:0]       state_req_code      // code carried by the pulse
);

    // ======================================================================
    // decoding helpers
    // codes 1 to 4 name a target bay state, 5 to 7 are reserved
    function automatic logic bcr_legal(input logic [2:0] code);
        bcr_legal = (code != `BCR_REQ_NONE) && (code <= `BCR_REQ_LAST_LEGAL);
    endfunction : bcr_legal

    function automatic logic bcr_hit(input logic [3:0] addr, input logic [3:0] ofs);
        bcr_hit = (addr == ofs);
    endfunction : bcr_hit

    bcr_av_req_t bus;
    bcr_state_t  state;
    bcr_state_t  next_state;
    logic        wr_ctl;
    logic [2:0]  wr_code;
    logic        wr_lock;
    logic [3:0]  wr_low;

    assign bus = '{avs_address, avs_read, avs_write, avs_writedata, avs_byteenable};

    // ======================================================================
    // write decode of the control register
    assign wr_ctl  = bus.write && (state.phase == BCR_IDLE)
                     && bcr_hit(bus.address, `BCR_OFS_CONTROL) && bus.byteenable[0];
    assign wr_code = bus.writedata[`BCR_REQ_HI:`BCR_REQ_LO]; // request field
    assign wr_lock = bus.writedata[`BCR_BIT_INTERLOCK];
    assign wr_low  = bus.writedata[`BCR_LOW_HI:`BCR_LOW_LO];

    // ======================================================================
    // next state
    always_comb begin
        next_state = state;
        next_state.state_req = '{1'b0, `BCR_REQ_NONE}; // pulse only, never held
        case (state.phase)
            BCR_IDLE: begin
                if (bus.read || bus.write) begin
                    next_state.phase = BCR_ANSWER;
                end
                if (bus.read) begin
                    if (bcr_hit(bus.address, `BCR_OFS_CONTROL)) begin
                        // upper bits always zero, field shows last write
                        next_state.readdata = {24'h00_0000, state.interlock,
                                               state.request, state.low_bits};
                    end else if (bcr_hit(bus.address, `BCR_OFS_PRESENCE)) begin
                        next_state.readdata = {31'h0000_0000, device_present};
                    end else begin
                        next_state.readdata = `BCR_UNMAPPED_DATA;
                    end
                end
            end
            BCR_ANSWER: begin
                next_state.phase = BCR_IDLE;
            end
            default: begin
                next_state.phase = BCR_IDLE;
            end
        endcase
        // override and clear from the bay state machine
        if (override_valid) begin
            next_state.request = override_code;
        end else if (request_clear) begin
            next_state.request = `BCR_REQ_NONE;
        end
        if (wr_ctl) begin
            // interlock, field and low bits in one update
            next_state.interlock = wr_lock;
            next_state.low_bits  = wr_low;
            if (wr_code != `BCR_REQ_NONE) begin
                next_state.request = wr_code; // stored even without device
            end
            // forward legal codes only at the write and with a device
            if (bcr_legal(wr_code) && device_present) begin
                next_state.state_req = '{1'b1, wr_code};
            end
        end
        // power refused and dropped while interlock released
        if (!next_state.interlock) begin
            next_state.low_bits[`BCR_BIT_POWER] = 1'b0;
        end
    end

    // ======================================================================
    // state register
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state           <= '0; // all zero, register reads 0
            state.phase     <= BCR_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ======================================================================
    // outputs
    assign avs_waitrequest   = (avs_read || avs_write) && (state.phase == BCR_IDLE);
    assign avs_readdata      = state.readdata;
    assign interlock_engage  = state.interlock;
    assign bay_state_request = state.request;
    assign bay_power_enable  = state.low_bits[`BCR_BIT_POWER];
    assign bay_enable_bits   = state.low_bits;
    assign state_req_valid   = state.state_req.valid;
    assign state_req_code    = state.state_req.code;

    // ======================================================================
    // checks
    sequence bcr_wr_legal_s;
        wr_ctl && bcr_legal(wr_code) && device_present;
    endsequence

    sequence bcr_pulse_s;
        state_req_valid && (state_req_code == $past(wr_code));
    endsequence

    reset_zero_a: assert property (@(posedge sys_clk) $rose(reset) |=>
        (avs_readdata == 32'h0000_0000) && !interlock_engage)
        else $error("control register not zero after reset");
    upper_zero_a: assert property (@(posedge sys_clk) disable iff (reset)
        $past(bus.read && bcr_hit(bus.address, `BCR_OFS_CONTROL) && state.phase == BCR_IDLE)
        |-> avs_readdata[31:8] == 24'h00_0000)
        else $error("upper control bits read nonzero");
    lock_follow_a: assert property (@(posedge sys_clk) disable iff (reset)
        wr_ctl |=> interlock_engage == $past(wr_lock))
        else $error("interlock does not follow bit 7");
    lock_power_a: assert property (@(posedge sys_clk) disable iff (reset)
        !interlock_engage |-> !bay_power_enable)
        else $error("power on with interlock released");
    pulse_legal_a: assert property (@(posedge sys_clk) disable iff (reset)
        bcr_wr_legal_s |=> bcr_pulse_s)
        else $error("legal request not forwarded");
    no_reserved_a: assert property (@(posedge sys_clk) disable iff (reset)
        state_req_valid |-> bcr_legal(state_req_code))
        else $error("reserved code forwarded");
    pulse_cause_a: assert property (@(posedge sys_clk) disable iff (reset)
        state_req_valid |-> $past(wr_ctl && device_present))
        else $error("request pulse without write and device");
    single_pulse_a: assert property (@(posedge sys_clk) disable iff (reset)
        state_req_valid |=> !state_req_valid)
        else $error("request held or queued");
    zero_keep_a: assert property (@(posedge sys_clk) disable iff (reset)
        wr_ctl && wr_code == `BCR_REQ_NONE && !override_valid && !request_clear
        |=> $stable(bay_state_request))
        else $error("zero write changed request field");
    store_absent_a: assert property (@(posedge sys_clk) disable iff (reset)
        wr_ctl && wr_code != `BCR_REQ_NONE && !device_present
        |=> bay_state_request == $past(wr_code) && !state_req_valid)
        else $error("absent-device write mishandled");

    // ======================================================================
    // further checks on the field, the interlock and the bus answer
    // a write that carries a nonzero code in the request field
    sequence bcr_wr_code_s;
        wr_ctl && (wr_code != `BCR_REQ_NONE);
    endsequence

    // a write that releases the interlock
    sequence bcr_wr_release_s;
        wr_ctl && !wr_lock;
    endsequence

    // a read of the control word taken in the idle phase
    sequence bcr_rd_ctl_s;
        bus.read && bcr_hit(bus.address, `BCR_OFS_CONTROL) && (state.phase == BCR_IDLE);
    endsequence

    lock_release_a: assert property (@(posedge sys_clk) disable iff (reset)
        bcr_wr_release_s |=> !interlock_engage && !bay_power_enable)
        else $error("interlock not released by zero in bit 7");
    code_store_a: assert property (@(posedge sys_clk) disable iff (reset)
        bcr_wr_code_s |=> bay_state_request == $past(wr_code))
        else $error("written request code not stored");
    field_read_a: assert property (@(posedge sys_clk) disable iff (reset)
        bcr_rd_ctl_s |=> avs_readdata[6:4] == $past(bay_state_request))
        else $error("request field readback differs from stored code");
    clear_field_a: assert property (@(posedge sys_clk) disable iff (reset)
        request_clear && !override_valid && !wr_ctl |=> bay_state_request == 3'h0)
        else $error("request field not cleared");
    override_load_a: assert property (@(posedge sys_clk) disable iff (reset)
        override_valid && !wr_ctl |=> bay_state_request == $past(override_code))
        else $error("override not loaded into request field");
    atomic_write_a: assert property (@(posedge sys_clk) disable iff (reset)
        bcr_wr_code_s |=> interlock_engage == $past(wr_lock)
        && bay_state_request == $past(wr_code)
        && bay_enable_bits[3:1] == $past(wr_low[3:1]))
        else $error("combined write not applied as one update");
    absent_quiet_a: assert property (@(posedge sys_clk) disable iff (reset)
        wr_ctl && !device_present |=> !state_req_valid)
        else $error("request pulse with empty bay");
    power_follow_a: assert property (@(posedge sys_clk) disable iff (reset)
        wr_ctl && wr_lock |=> bay_power_enable == $past(wr_low[0]))
        else $error("power bit does not follow write with interlock engaged");
    reset_quiet_a: assert property (@(posedge sys_clk)
        reset |-> !interlock_engage && bay_state_request == 3'h0 && !state_req_valid)
        else $error("outputs not quiet during reset");
    bus_answer_a: assert property (@(posedge sys_clk) disable iff (reset)
        (avs_read || avs_write) && state.phase == BCR_IDLE |=> state.phase == BCR_ANSWER)
        else $error("bus request not answered in next cycle");

endmodule : bcr_bay_control

`default_nettype wire

// ---- core/bcr_consts.svh ----
// constants of the bay control register: offsets, fields, reset values
`ifndef BCR_CONSTS_SVH
`define BCR_CONSTS_SVH

// ==========================================================================
// register map (byte addresses, one word each)
`define BCR_OFS_CONTROL    4'h0
`define BCR_OFS_PRESENCE   4'h4
`define BCR_CONTROL_RESET  32'h0000_0000

// ==========================================================================
// field positions
`define BCR_BIT_INTERLOCK  7
`define BCR_REQ_HI         6
`define BCR_REQ_LO         4
`define BCR_BIT_POWER      0
`define BCR_LOW_HI         3
`define BCR_LOW_LO         0

// ==========================================================================
// request codes
`define BCR_REQ_NONE       3'h0
`define BCR_REQ_INSERTED   3'h1
`define BCR_REQ_ENABLED    3'h2
`define BCR_REQ_REMOVAL    3'h3
`define BCR_REQ_ALLOWED    3'h4
`define BCR_REQ_LAST_LEGAL 3'h4

// ==========================================================================
// bus answer for unmapped reads
`define BCR_UNMAPPED_DATA  32'h0000_0000

`endif

// ---- core/bcr_pkg.sv ----
// types shared by the bay control register design
package bcr_pkg;

    // ======================================================================
    // Avalon-MM slave request
    typedef struct packed {
        logic [3:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } bcr_av_req_t;

    // ======================================================================
    // state change request towards the bay state machine
    typedef struct packed {
        logic       valid;
        logic [2:0] code;
    } bcr_state_req_t;

    // ======================================================================
    // bus phase
    typedef enum logic [0:0] {
        BCR_IDLE,
        BCR_ANSWER
    } bcr_phase_t;

    // ======================================================================
    // all state of the block
    typedef struct packed {
        bcr_phase_t     phase;
        logic           interlock;
        logic [2:0]     request;
        logic [3:0]     low_bits;
        logic [31:0]    readdata;
        bcr_state_req_t state_req;
    } bcr_state_t;

endpackage : bcr_pkg

// ---- test/test_bcr_bay_control.sv ----
// self-checking bench for the bay control register
`timescale 1ns/100ps
`default_nettype none
`include "bcr_consts.svh"
module test_bcr_bay_control import bcr_pkg::*;;
    // ======================================================================
    // signals
    logic        sys_clk, reset, avs_read, avs_write, avs_waitrequest;
    logic [3:0]  avs_address, avs_byteenable, bay_enable_bits;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic        device_present, request_clear, override_valid, interlock_engage;
    logic        bay_power_enable, state_req_valid, pv;
    logic [2:0]  override_code, bay_state_request, state_req_code, pc;
    int          n_fail, n_checks;

    // clock, 5 ns period
    always #2.5 sys_clk = ~sys_clk;

    bcr_bay_control dut_u (
        .sys_clk(sys_clk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .device_present(device_present),
        .request_clear(request_clear), .override_valid(override_valid),
        .override_code(override_code), .interlock_engage(interlock_engage),
        .bay_state_request(bay_state_request), .bay_power_enable(bay_power_enable),
        .bay_enable_bits(bay_enable_bits), .state_req_valid(state_req_valid),
        .state_req_code(state_req_code)
    );

    // ======================================================================
    // verdict and comparison
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // one avalon access; held until waitrequest is seen low, pulse captured there
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        int i;
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        avs_write      <= wr;
        avs_read       <= ~wr;
        i = 0;
        @(negedge sys_clk);
        while (avs_waitrequest !== 1'b0 && i < 16) begin
            @(negedge sys_clk);
            i++;
        end
        if (avs_waitrequest !== 1'b0) begin
            n_fail++;
            wrap_up();
        end
        // settled values that stand at the edge where waitrequest is low
        pv = state_req_valid;
        pc = state_req_code;
        rd = avs_readdata;
        @(posedge sys_clk);
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge sys_clk);
    endtask : bus

    // ======================================================================
    // main sequence
    initial begin
        {sys_clk, avs_read, avs_write, request_clear, override_valid} = '0;
        {avs_address, avs_byteenable, avs_writedata, override_code} = '0;
        reset = 1'b1;
        device_present = 1'b1;
        n_fail = 0;
        n_checks = 0;
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        bus(1'b0, `BCR_OFS_CONTROL, 32'h0, 4'hf);
        check("control after reset", rd, `BCR_CONTROL_RESET);
        check("interlock after reset", 32'(interlock_engage), 32'h0);
        // upper bits dropped, interlock and request land in one write
        bus(1'b1, `BCR_OFS_CONTROL, 32'hffff_ff9f, 4'hf);
        check("pulse inserted", 32'({pv, pc}), 32'h9);
        check("interlock engaged", 32'(interlock_engage), 32'h1);
        check("enable bits", 32'(bay_enable_bits), 32'hf);
        bus(1'b0, `BCR_OFS_CONTROL, 32'h0, 4'hf);
        check("control readback", rd, 32'h0000_009f);
        $display("test reset and layout done");
        // every request code, legal ones pulse, reserved ones only stored
        for (int c = 1; c < 8; c++) begin
            bus(1'b1, `BCR_OFS_CONTROL, {24'h0, 1'b1, 3'(c), 4'h0}, 4'hf);
            check("pulse valid", 32'(pv), 32'(c <= 4));
            if (c <= 4) check("pulse code", 32'(pc), 32'(c));
            bus(1'b0, `BCR_OFS_CONTROL, 32'h0, 4'hf);
            check("field readback", 32'(rd[6:4]), 32'(c));
            check("field output", 32'(bay_state_request), 32'(c));
        end
        // zero code keeps the field and requests nothing
        bus(1'b1, `BCR_OFS_CONTROL, 32'h80, 4'hf);
        check("zero write pulse", 32'(pv), 32'h0);
        check("zero write field", 32'(bay_state_request), 32'h7);
        $display("test request codes done");
        // no device: stored, no pulse, and no late pulse on insertion
        device_present <= 1'b0;
        bus(1'b1, `BCR_OFS_CONTROL, 32'ha0, 4'hf);
        check("empty bay pulse", 32'(pv), 32'h0);
        check("empty bay field", 32'(bay_state_request), 32'h2);
        device_present <= 1'b1;
        repeat (4) begin
            @(negedge sys_clk);
            check("no queued pulse", 32'(state_req_valid), 32'h0);
        end
        @(posedge sys_clk);
        $display("test presence done");
        // power depends on the interlock
        bus(1'b1, `BCR_OFS_CONTROL, 32'h01, 4'hf);
        check("interlock released", 32'(interlock_engage), 32'h0);
        check("power refused", 32'(bay_power_enable), 32'h0);
        bus(1'b0, `BCR_OFS_CONTROL, 32'h0, 4'hf);
        check("power refused read", rd, 32'h20);
        bus(1'b1, `BCR_OFS_CONTROL, 32'h81, 4'hf);
        check("power granted", 32'(bay_power_enable), 32'h1);
        bus(1'b1, `BCR_OFS_CONTROL, 32'h00, 4'hf);
        check("power dropped", 32'(bay_power_enable), 32'h0);
        $display("test power done");
        // device side clear and override of the field
        request_clear <= 1'b1;
        @(posedge sys_clk);
        request_clear <= 1'b0;
        bus(1'b0, `BCR_OFS_CONTROL, 32'h0, 4'hf);
        check("field cleared", 32'(rd[6:4]), 32'h0);
        override_code  <= 3'h3;
        override_valid <= 1'b1;
        @(posedge sys_clk);
        override_valid <= 1'b0;
        bus(1'b0, `BCR_OFS_CONTROL, 32'h0, 4'hf);
        check("field overridden", rd, 32'h30);
        $display("test clear and override done");
        // refused accesses, then presence and unmapped reads
        bus(1'b1, `BCR_OFS_PRESENCE, 32'hf0, 4'hf);
        bus(1'b1, `BCR_OFS_CONTROL, 32'hf0, 4'he);
        bus(1'b0, `BCR_OFS_CONTROL, 32'h0, 4'hf);
        check("ignored writes", rd, 32'h30);
        bus(1'b0, `BCR_OFS_PRESENCE, 32'h0, 4'hf);
        check("presence read", rd, 32'h1);
        bus(1'b0, 4'h8, 32'h0, 4'hf);
        check("unmapped read", rd, `BCR_UNMAPPED_DATA);
        $display("test refusals done");
        wrap_up();
    end
endmodule : test_bcr_bay_control
`default_nettype wire
